//--- shared/logic_pc_pkg.sv
// Package: encodings, field positions and carriers for the logic/PC unit
`default_nettype none
package logic_pc_pkg;
  localparam logic [5:0] OP_RTYPE = 6'h3a;
  localparam logic [5:0] OP_ORHI = 6'h34;
  localparam logic [5:0] OP_ORI = 6'h14;
  localparam logic [5:0] OPX_NEXTADDR = 6'h1c;
  localparam logic [5:0] OPX_NOR = 6'h06;
  localparam logic [5:0] OPX_OR = 6'h16;
  localparam logic [5:0] OPX_ADD = 6'h31;
  localparam logic [31:0] PC_STEP = 32'h00000004;
  localparam logic [31:0] PC_RESET = 32'h00000000;
  localparam logic [15:0] HALF_ZERO = 16'h0000;
  localparam logic [4:0] ZERO_IDX = 5'h00;
  localparam int FA_LSB = 27;
  localparam int FB_LSB = 22;
  localparam int FC_LSB = 17;
  localparam int LIT_LSB = 6;
  localparam int OPX_LSB = 11;
  localparam int SHAMT_LSB = 6;

  // Decoded instruction word
  typedef struct packed {
    logic [4:0] first_source_register;
    logic [4:0] second_source_register;
    logic [4:0] destination_register;
    logic [15:0] sixteen_bit_literal;
    logic [5:0] opx;
    logic [4:0] shamt;
    logic [5:0] op;
  } fields_t;

  // Write-back to the register file
  typedef struct packed {
    logic en;
    logic [4:0] idx;
    logic [31:0] data;
  } wb_t;
endpackage
`default_nettype wire

//--- verilog/field_split.sv
// Splits an instruction word into its R-format and I-format fields
`timescale 1ns/10ps
`default_nettype none
module field_split (
  input wire logic [31:0] word,
  output logic_pc_pkg::fields_t fields
);
  // Both formats share A, B and opcode positions; C, OPX only matter for R
  assign fields.first_source_register =
    word[logic_pc_pkg::FA_LSB +: 5];
  assign fields.second_source_register =
    word[logic_pc_pkg::FB_LSB +: 5];
  assign fields.destination_register =
    word[logic_pc_pkg::FC_LSB +: 5];
  assign fields.sixteen_bit_literal =
    word[logic_pc_pkg::LIT_LSB +: 16];
  assign fields.opx = word[logic_pc_pkg::OPX_LSB +: 6];
  assign fields.shamt = word[logic_pc_pkg::SHAMT_LSB +: 5];
  assign fields.op = word[5:0];
endmodule
`default_nettype wire

//--- verilog/logic_pc_unit.sv
// Decode/execute stage for next-address, nop, nor, or, orhi and ori
// Function
// - Next-address op writes PC plus 4 to destination; opx 1c, op 3a.
// - Only next-address op puts the PC value into a general register.
// - Nop is add of zero registers; only the PC advances.
// - Opx 06 under op 3a writes NOR of both sources to destination.
// - Opx 16 under op 3a writes OR of both sources to destination.
// - Op 34 ORs first source with high-half literal into second field.
// - Op 14: first source OR zero-extended literal, to second field.
// - I-format fields: A 31-27, B 26-22, literal 21-6, opcode 5-0.
// - R-format fields: A, B, C, opx 16-11, zero 10-6, op 3a.
`timescale 1ns/10ps
`default_nettype none
module logic_pc_unit (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] SRC_A_DATA,
  input wire logic [31:0] SRC_B_DATA,
  output logic [4:0] SRC_A_IDX,
  output logic [4:0] SRC_B_IDX,
  output logic WB_EN,
  output logic [4:0] WB_IDX,
  output logic [31:0] WB_DATA,
  output logic [31:0] PC,
  output logic DONE,
  output logic UNHANDLED
);
  typedef enum logic [1:0] {
    S_FETCH = 2'b01,
    S_EXEC = 2'b10
  } state_t;

  state_t state;
  state_t next_state;
  logic [31:0] iword;
  logic_pc_pkg::fields_t f;
  logic_pc_pkg::wb_t next_wb;

  field_split u_split (
    .word(iword),
    .fields(f)
  );

  // Register file read ports are driven from the latched word
  function automatic logic [4:0] idx_a(input logic [31:0] w);
    return w[logic_pc_pkg::FA_LSB +: 5];
  endfunction

  function automatic logic [4:0] idx_b(input logic [31:0] w);
    return w[logic_pc_pkg::FB_LSB +: 5];
  endfunction

  // Opcode decode
  wire is_r = f.op == logic_pc_pkg::OP_RTYPE
    && f.shamt == 5'h00;
  wire is_next = is_r && f.opx == logic_pc_pkg::OPX_NEXTADDR
    && f.first_source_register == logic_pc_pkg::ZERO_IDX
    && f.second_source_register == logic_pc_pkg::ZERO_IDX;
  wire is_nor = is_r && f.opx == logic_pc_pkg::OPX_NOR;
  wire is_or = is_r && f.opx == logic_pc_pkg::OPX_OR;
  // Nop arrives as an add on the zero register; any add into it is harmless
  wire is_nop = is_r && f.opx == logic_pc_pkg::OPX_ADD
    && f.destination_register == logic_pc_pkg::ZERO_IDX;
  wire is_orhi = f.op == logic_pc_pkg::OP_ORHI;
  wire is_ori = f.op == logic_pc_pkg::OP_ORI;
  wire handled = is_next | is_nor | is_or | is_nop | is_orhi | is_ori;

  // Result selection; PC only reaches the data path through is_next
  wire [31:0] or_ab = SRC_A_DATA | SRC_B_DATA;
  wire [31:0] lit_hi = {f.sixteen_bit_literal, logic_pc_pkg::HALF_ZERO};
  wire [31:0] lit_lo = {logic_pc_pkg::HALF_ZERO, f.sixteen_bit_literal};
  wire [31:0] pc_plus = PC + logic_pc_pkg::PC_STEP;
  wire [31:0] result = is_next ? pc_plus
    : is_nor ? ~or_ab
    : is_or ? or_ab
    : is_orhi ? (SRC_A_DATA | lit_hi)
    : (SRC_A_DATA | lit_lo);
  wire [4:0] dest = (is_orhi | is_ori) ? f.second_source_register
    : f.destination_register;
  // Writes to the zero register are squashed here, so nop has no effect
  wire wr_ok = handled && !is_nop
    && dest != logic_pc_pkg::ZERO_IDX;

  assign next_wb.en = state == S_EXEC && wr_ok;
  assign next_wb.idx = dest;
  assign next_wb.data = result;
  assign SRC_A_IDX = idx_a(iword);
  assign SRC_B_IDX = idx_b(iword);

  // Two-cycle sequence: latch word, then execute and retire
  always_comb begin
    case (state)
      S_FETCH: next_state = INSTR_VALID ? S_EXEC : S_FETCH;
      S_EXEC: next_state = S_FETCH;
      default: next_state = S_FETCH;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state <= S_FETCH;
      iword <= 32'h00000000;
    end else begin
      state <= next_state;
      if (state == S_FETCH && INSTR_VALID) iword <= INSTR_WORD;
    end
  end

  // Retire: one write, PC to the next word, never an exception
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      WB_EN <= 1'b0;
      WB_IDX <= 5'h00;
      WB_DATA <= 32'h00000000;
      PC <= logic_pc_pkg::PC_RESET;
      DONE <= 1'b0;
      UNHANDLED <= 1'b0;
    end else begin
      WB_EN <= next_wb.en;
      WB_IDX <= next_wb.idx;
      WB_DATA <= next_wb.data;
      DONE <= state == S_EXEC;
      UNHANDLED <= state == S_EXEC && !handled;
      if (state == S_EXEC) PC <= pc_plus;
    end
  end

  // Assertions
  sequence s_exec_next;
    state == S_EXEC && is_next && f.destination_register != 5'h00;
  endsequence

  property p_nextpc;
    @(posedge CLK_SYS) disable iff (SRST)
      s_exec_next |=> WB_EN && WB_DATA == $past(PC) + 32'h4;
  endproperty
  a_nextpc: assert property (p_nextpc)
    else $error("nextaddr value");

  property p_pc_only_next;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && !is_next && !is_orhi && !is_ori && handled
      |=> WB_DATA == ~($past(SRC_A_DATA) | $past(SRC_B_DATA))
      || WB_DATA == ($past(SRC_A_DATA) | $past(SRC_B_DATA)) || !WB_EN;
  endproperty
  a_pc_only_next: assert property (p_pc_only_next)
    else $error("pc leak");

  property p_nop;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && is_nop |=> !WB_EN && PC == $past(PC) + 32'h4;
  endproperty
  a_nop: assert property (p_nop) else $error("nop wrote");

  property p_nor;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && is_nor && f.destination_register != 5'h00
      |=> WB_EN && WB_DATA == ~($past(SRC_A_DATA) | $past(SRC_B_DATA));
  endproperty
  a_nor: assert property (p_nor) else $error("nor result");

  property p_or;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && is_or && f.destination_register != 5'h00
      |=> WB_EN && WB_DATA == ($past(SRC_A_DATA) | $past(SRC_B_DATA));
  endproperty
  a_or: assert property (p_or) else $error("or result");

  property p_orhi;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && is_orhi |=> WB_IDX == $past(iword[26:22])
      && WB_DATA == ($past(SRC_A_DATA) | {$past(iword[21:6]), 16'h0000});
  endproperty
  a_orhi: assert property (p_orhi) else $error("orhi result");

  property p_ori;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && is_ori |=> WB_IDX == $past(iword[26:22])
      && WB_DATA == ($past(SRC_A_DATA) | {16'h0000, $past(iword[21:6])});
  endproperty
  a_ori: assert property (p_ori) else $error("ori result");

  property p_fields;
    @(posedge CLK_SYS) disable iff (SRST)
      SRC_A_IDX == iword[31:27] && SRC_B_IDX == iword[26:22];
  endproperty
  a_fields: assert property (p_fields) else $error("field pos");

  property p_rfmt;
    @(posedge CLK_SYS) disable iff (SRST)
      state == S_EXEC && iword[10:6] != 5'h00 && iword[5:0] == 6'h3a
      |=> !WB_EN && UNHANDLED;
  endproperty
  a_rfmt: assert property (p_rfmt)
    else $error("bad R zero field");

  property p_zero;
    @(posedge CLK_SYS) disable iff (SRST) WB_EN |-> WB_IDX != 5'h00;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero reg written");

  // A take, then two edges later the retire with the PC one word on
  sequence s_take;
    state == S_FETCH && INSTR_VALID;
  endsequence

  property p_step;
    @(posedge CLK_SYS) disable iff (SRST)
      s_take |=> ##1 DONE && PC == $past(PC, 2) + 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("pc step");

  // Retire is a lone pulse, so no op can write twice
  property p_single_retire;
    @(posedge CLK_SYS) disable iff (SRST)
      DONE |=> !DONE && !WB_EN;
  endproperty
  a_single_retire: assert property (p_single_retire)
    else $error("double retire");

  // Words outside this unit retire quietly instead of trapping
  property p_unhandled_quiet;
    @(posedge CLK_SYS) disable iff (SRST)
      UNHANDLED |-> DONE && !WB_EN;
  endproperty
  a_unhandled_quiet: assert property (p_unhandled_quiet)
    else $error("unhandled wrote");
endmodule
`default_nettype wire

//--- bench/logic_pc_unit_test.sv
// Self-checking bench for the logic and next-address unit
`timescale 1ns/10ps
`default_nettype none
module logic_pc_unit_test;
  logic CLK_SYS = 1'b0;
  logic SRST = 1'b1;
  logic INSTR_VALID = 1'b0;
  logic [31:0] INSTR_WORD = 32'h00000000;
  logic [31:0] SRC_A_DATA, SRC_B_DATA, WB_DATA, PC;
  logic [4:0] SRC_A_IDX, SRC_B_IDX, WB_IDX;
  logic WB_EN, DONE, UNHANDLED;
  logic [31:0] pc_exp = 32'h00000000;
  int n_fail = 0;
  int comparisons = 0;

  // Register file stand-in: each index reads a distinct pattern, zero reads 0
  function automatic logic [31:0] rv(input logic [4:0] i);
    return (i == 5'h00) ? 32'h00000000 : {4{3'h5, i}};
  endfunction
  function automatic logic [31:0] rw(input logic [4:0] a, b, c,
                                     input logic [5:0] x);
    return {a, b, c, x, 5'h00, logic_pc_pkg::OP_RTYPE};
  endfunction
  function automatic logic [31:0] iw(input logic [4:0] a, b,
                                     input logic [15:0] k,
                                     input logic [5:0] op);
    return {a, b, k, op};
  endfunction

  assign SRC_A_DATA = rv(SRC_A_IDX);
  assign SRC_B_DATA = rv(SRC_B_IDX);
  always #10 CLK_SYS = ~CLK_SYS;

  logic_pc_unit dut (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
    .SRC_A_DATA(SRC_A_DATA), .SRC_B_DATA(SRC_B_DATA),
    .SRC_A_IDX(SRC_A_IDX), .SRC_B_IDX(SRC_B_IDX), .WB_EN(WB_EN),
    .WB_IDX(WB_IDX), .WB_DATA(WB_DATA), .PC(PC), .DONE(DONE),
    .UNHANDLED(UNHANDLED));

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One instruction: offer, drop, then judge the retire two edges later
  task automatic run(input logic [31:0] word, input logic en,
                     input logic [4:0] idx, input logic [31:0] data,
                     input logic unh);
    @(negedge CLK_SYS);
    INSTR_VALID = 1'b1;
    INSTR_WORD = word;
    @(negedge CLK_SYS);
    INSTR_VALID = 1'b0;
    check("early done", DONE, 1'b0);
    check("src_a_idx", SRC_A_IDX, word[31:27]);
    check("src_b_idx", SRC_B_IDX, word[26:22]);
    @(negedge CLK_SYS);
    check("done", DONE, 1'b1);
    check("wb_en", WB_EN, en);
    if (en) begin
      check("wb_idx", WB_IDX, idx);
      check("wb_data", WB_DATA, data);
    end
    check("unhandled", UNHANDLED, unh);
    pc_exp = pc_exp + logic_pc_pkg::PC_STEP;
    check("pc", PC, pc_exp);
  endtask

  task automatic t_nextpc;
    run(rw(5'h00, 5'h00, 5'h06, logic_pc_pkg::OPX_NEXTADDR), 1'b1, 5'h06,
        pc_exp + 32'h00000004, 1'b0);
    run(rw(5'h03, 5'h00, 5'h06, logic_pc_pkg::OPX_NEXTADDR), 1'b0, 5'h00,
        32'h00000000, 1'b1);
  endtask
  task automatic t_nop;
    run(rw(5'h00, 5'h00, 5'h00, logic_pc_pkg::OPX_ADD), 1'b0, 5'h00,
        32'h00000000, 1'b0);
  endtask
  task automatic t_nor_or;
    run(rw(5'h07, 5'h08, 5'h06, logic_pc_pkg::OPX_NOR), 1'b1, 5'h06,
        ~(rv(5'h07) | rv(5'h08)), 1'b0);
    run(rw(5'h07, 5'h08, 5'h09, logic_pc_pkg::OPX_OR), 1'b1, 5'h09,
        rv(5'h07) | rv(5'h08), 1'b0);
    run(rw(5'h00, 5'h08, 5'h1f, logic_pc_pkg::OPX_OR), 1'b1, 5'h1f,
        rv(5'h08), 1'b0);
  endtask
  task automatic t_imm;
    run(iw(5'h03, 5'h09, 16'hffff, logic_pc_pkg::OP_ORHI), 1'b1, 5'h09,
        rv(5'h03) | 32'hffff0000, 1'b0);
    run(iw(5'h00, 5'h0a, 16'h0064, logic_pc_pkg::OP_ORHI), 1'b1, 5'h0a,
        32'h00640000, 1'b0);
    run(iw(5'h11, 5'h02, 16'h8001, logic_pc_pkg::OP_ORI), 1'b1, 5'h02,
        rv(5'h11) | 32'h00008001, 1'b0);
    // Zero first source exposes the literal alone: low half, no sign fill
    run(iw(5'h00, 5'h0b, 16'h8001, logic_pc_pkg::OP_ORI), 1'b1, 5'h0b,
        32'h00008001, 1'b0);
  endtask
  // Zero destination and a nonzero reserved field must not write
  task automatic t_refuse;
    run(rw(5'h07, 5'h08, 5'h00, logic_pc_pkg::OPX_OR), 1'b0, 5'h00,
        32'h00000000, 1'b0);
    run(iw(5'h07, 5'h00, 16'h1234, logic_pc_pkg::OP_ORI), 1'b0, 5'h00,
        32'h00000000, 1'b0);
    run(rw(5'h07, 5'h08, 5'h06, logic_pc_pkg::OPX_OR) | 32'h00000040,
        1'b0, 5'h00, 32'h00000000, 1'b1);
  endtask

  // Watchdog: the whole sequence needs well under a hundred cycles
  initial begin
    repeat (500) @(posedge CLK_SYS);
    n_fail++;
    summarize();
  end

  initial begin
    repeat (6) @(negedge CLK_SYS);
    check("reset pc", PC, logic_pc_pkg::PC_RESET);
    check("reset wb_en", WB_EN, 1'b0);
    SRST = 1'b0;
    t_nextpc();
    t_nop();
    t_nor_or();
    t_imm();
    t_refuse();
    summarize();
  end
endmodule
`default_nettype wire
